/* logic/vipu_core.sv */
// Vectored interrupt priority unit: registers, pending flags, entry and return sequencer
// Functional notes
// - Highest level first; lowest vector within level
// - Groups A=0,1 B=2,3,4 C=5,6,7
// - Priority bits 7,4,1 order the groups
// - Bits 5,2,3,0 order levels inside groups
// - Status bit n shows request on level n
// - Status register read-only, zero after reset
// - Requests recorded while disabled, not serviced until enabled
// - Hardware pending flag set, pulsed, auto-cleared
// - Levels 0 to 3 are hardware-cleared
// - Service needs global enable, unmask, priority, source
// - Acknowledge at end of instruction cycle
// - Entry clears global enable, saves; only normal entry fetches vector
// - Return restores PC, flags, sets global enable
// - Push PC low, PC high, flags; fetch vector
// - Vectors even, in 00-FF, skip 3C-3F
// - Fast entry six cycles, normal twenty-two
// - Mode bits 4:2 pick fast level, bit1 enables
// - Fast entry swaps pointer, shadows flags, sets status
// - Fast return swaps back, restores flags, clears status
// - Global enable gates fast; mode bit1 switches it
// - Reset clears mode bits 7, 1, 0
// - Mask bit zero masks level, one enables
module vipu_core
	import vipu_pkg::*;
#(
	parameter logic [7:0] VEC_BASE = 8'hc0
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [vipu_pkg::VIPU_NSRC-1:0] src_event,
	input wire logic [vipu_pkg::VIPU_NSRC-1:0] src_flag,
	input wire logic [vipu_pkg::VIPU_NSRC-1:0] src_enable,
	input wire logic instr_end,
	input wire logic return_from_int,
	input wire logic global_int_on,
	input wire logic global_int_off,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] flags_in,
	input wire logic [7:0] pop_data,
	input wire logic [7:0] vec_data,
	output logic irq_pulse,
	output logic int_acknowledge,
	output logic stack_push,
	output logic [7:0] stack_data,
	output logic stack_pop,
	output logic vec_rd,
	output logic [7:0] vec_addr,
	output logic pc_load,
	output logic [15:0] pc_value,
	output logic flags_load,
	output logic [7:0] flags_value,
	output logic fast_status
);

	import vipu_pkg::*;

	typedef struct packed {
		vipu_state_e st;
		logic [4:0] cnt;
		logic is_fast;
		logic [7:0] mask;
		logic [7:0] prio;
		logic [7:0] system_mode;
		logic [7:0] fvp_h;
		logic [7:0] fvp_l;
		logic [7:0] req_stat;
		logic [7:0] shadow;
		logic [VIPU_NSRC-1:0] hw_pend;
		logic [15:0] pc_save;
		logic [7:0] flags_save;
		logic [7:0] vec;
		logic [15:0] target;
		logic [7:0] rdata;
		logic irq;
		logic ack;
		logic push;
		logic [7:0] push_data;
		logic pop;
		logic vrd;
		logic [7:0] vaddr;
		logic pcl;
		logic [15:0] pcv;
		logic fll;
		logic [7:0] flv;
		logic fstat;
	} vipu_regs_s;

	vipu_regs_s r_reg;
	vipu_regs_s r_next;

	// ----------------------------------------
	// Pending flags and level requests
	// ----------------------------------------
	logic [VIPU_NSRC-1:0] pend;
	logic [VIPU_NSRC-1:0] hw_pend_next;
	logic [VIPU_NSRC-1:0] ack_clr;
	logic [VIPU_NSRC-1:0] hw_evt;
	logic [7:0] lvl_req;
	logic [VIPU_SRCS-1:0] lvl_src [VIPU_LVLS];

	genvar gi;
	generate
		for (gi = 0; gi < VIPU_NSRC; gi++) begin : g_src
			localparam int LV = gi / VIPU_SRCS;
			if (VIPU_HW_CLR_LEVELS[LV]) begin : g_hw
				// Set wins over the acknowledge clear so a back-to-back event is kept
				assign hw_pend_next[gi] = src_event[gi] | (r_reg.hw_pend[gi] & ~ack_clr[gi]);
				assign pend[gi] = r_reg.hw_pend[gi];
				assign hw_evt[gi] = src_event[gi] & src_enable[gi];
			end else begin : g_sw
				// Peripheral holds its own pending bit until software clears it
				assign hw_pend_next[gi] = 1'b0;
				assign pend[gi] = src_flag[gi];
				assign hw_evt[gi] = 1'b0;
			end
			assign lvl_src[LV][gi % VIPU_SRCS] = pend[gi] & src_enable[gi];
		end
		for (gi = 0; gi < VIPU_LVLS; gi++) begin : g_lvl
			assign lvl_req[gi] = |lvl_src[gi];
		end
	endgenerate

	// ----------------------------------------
	// Priority and vector selection
	// ----------------------------------------
	logic win_found;
	logic [2:0] win_lvl;
	logic [1:0] win_src;
	logic [7:0] win_vec;
	logic win_fast;
	logic accept;

	vipu_prio_resolve u_resolve (
		.req(r_reg.req_stat & r_reg.mask),
		.prio(r_reg.prio),
		.found(win_found),
		.level(win_lvl)
	);

	always_comb begin
		win_src = 2'h0;
		for (int s = VIPU_SRCS - 1; s >= 0; s--) begin
			if (lvl_src[win_lvl][s]) begin
				win_src = s[1:0];
			end
		end
		win_vec = VEC_BASE + {2'h0, win_lvl, win_src, 1'b0};
		win_fast = r_reg.system_mode[VIPU_SYM_FAST_EN] &&
			(r_reg.system_mode[VIPU_SYM_FSEL_LSB +: 3] == win_lvl);
		// Status register only feeds service once the request is still live
		accept = (r_reg.st == VIPU_IDLE) && instr_end && !return_from_int &&
			r_reg.system_mode[VIPU_SYM_GIE] && win_found && lvl_req[win_lvl];
		ack_clr = '0;
		if (accept) begin
			ack_clr[{win_lvl, win_src}] = 1'b1;
		end
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.irq = |hw_evt;
		r_next.ack = 1'b0;
		r_next.push = 1'b0;
		r_next.pop = 1'b0;
		r_next.vrd = 1'b0;
		r_next.pcl = 1'b0;
		r_next.fll = 1'b0;
		r_next.hw_pend = hw_pend_next;
		r_next.req_stat = lvl_req;
		r_next.cnt = r_reg.cnt + 5'h1;

		// Register writes; the status register ignores writes
		if (reg_wr) begin
			case (reg_addr)
				VIPU_OFS_FVP_HIGH: r_next.fvp_h = reg_wdata;
				VIPU_OFS_FVP_LOW: r_next.fvp_l = reg_wdata;
				VIPU_OFS_LEVEL_MASK: r_next.mask = reg_wdata;
				VIPU_OFS_SYSTEM_MODE: r_next.system_mode = reg_wdata & VIPU_SYM_USED;
				VIPU_OFS_LEVEL_PRIO: r_next.prio = reg_wdata;
				default: r_next.mask = r_next.mask;
			endcase
		end
		if (global_int_on) begin
			r_next.system_mode[VIPU_SYM_GIE] = 1'b1;
		end
		if (global_int_off) begin
			r_next.system_mode[VIPU_SYM_GIE] = 1'b0;
		end

		// Read port, registered; unmapped addresses read zero
		case (reg_addr)
			VIPU_OFS_FVP_HIGH: r_next.rdata = r_reg.fvp_h;
			VIPU_OFS_FVP_LOW: r_next.rdata = r_reg.fvp_l;
			VIPU_OFS_REQ_STATUS: r_next.rdata = r_reg.req_stat;
			VIPU_OFS_LEVEL_MASK: r_next.rdata = r_reg.mask;
			VIPU_OFS_SYSTEM_MODE: r_next.rdata = r_reg.system_mode;
			VIPU_OFS_LEVEL_PRIO: r_next.rdata = r_reg.prio;
			default: r_next.rdata = 8'h00;
		endcase

		case (r_reg.st)
			VIPU_IDLE: begin
				if (return_from_int && r_reg.fstat) begin
					// Swap pointer and PC back, restore shadow flags
					r_next.pcl = 1'b1;
					r_next.pcv = {r_reg.fvp_h, r_reg.fvp_l};
					{r_next.fvp_h, r_next.fvp_l} = pc_in;
					r_next.fll = 1'b1;
					r_next.flv = r_reg.shadow;
					r_next.fstat = 1'b0;
					r_next.system_mode[VIPU_SYM_GIE] = 1'b1;
				end else if (return_from_int) begin
					r_next.pop = 1'b1;
					r_next.st = VIPU_POP_F;
				end else if (accept) begin
					// Entry always wins over a register write to the enable bit
					r_next.system_mode[VIPU_SYM_GIE] = 1'b0;
					r_next.ack = 1'b1;
					r_next.cnt = 5'h1;
					r_next.is_fast = win_fast;
					r_next.vec = win_vec;
					if (win_fast) begin
						r_next.target = {r_reg.fvp_h, r_reg.fvp_l};
						{r_next.fvp_h, r_next.fvp_l} = pc_in;
						r_next.shadow = flags_in;
						r_next.st = VIPU_FAST;
					end else begin
						r_next.pc_save = pc_in;
						r_next.flags_save = flags_in;
						r_next.push = 1'b1;
						r_next.push_data = pc_in[7:0];
						r_next.st = VIPU_PUSH_H;
					end
				end
			end
			VIPU_PUSH_H: begin
				r_next.push = 1'b1;
				r_next.push_data = r_reg.pc_save[15:8];
				r_next.st = VIPU_PUSH_F;
			end
			VIPU_PUSH_F: begin
				r_next.push = 1'b1;
				r_next.push_data = r_reg.flags_save;
				r_next.st = VIPU_FETCH_H;
			end
			VIPU_FETCH_H: begin
				r_next.vrd = 1'b1;
				r_next.vaddr = r_reg.vec;
				r_next.st = VIPU_FETCH_L;
			end
			VIPU_FETCH_L: begin
				r_next.vrd = 1'b1;
				r_next.vaddr = r_reg.vec + 8'h01;
				r_next.st = VIPU_CAPT;
			end
			VIPU_CAPT: begin
				r_next.target[15:8] = vec_data;
				r_next.st = VIPU_BRANCH;
			end
			VIPU_BRANCH: begin
				if (r_reg.cnt == 5'(VIPU_NORMAL_ENTRY_CYC - 1)) begin
					r_next.pcl = 1'b1;
					r_next.pcv = r_reg.target;
					r_next.st = VIPU_IDLE;
				end
				if (r_reg.cnt == 5'h8) begin
					r_next.target[7:0] = vec_data;
				end
			end
			VIPU_FAST: begin
				if (r_reg.cnt == 5'(VIPU_FAST_ENTRY_CYC - 1)) begin
					r_next.pcl = 1'b1;
					r_next.pcv = r_reg.target;
					r_next.fstat = 1'b1;
					r_next.st = VIPU_IDLE;
				end
			end
			VIPU_POP_F: begin
				r_next.pop = 1'b1;
				r_next.flags_save = pop_data;
				r_next.st = VIPU_POP_H;
			end
			VIPU_POP_H: begin
				r_next.pop = 1'b1;
				r_next.pc_save[15:8] = pop_data;
				r_next.st = VIPU_POP_L;
			end
			VIPU_POP_L: begin
				r_next.pcl = 1'b1;
				r_next.pcv = {r_reg.pc_save[15:8], pop_data};
				r_next.fll = 1'b1;
				r_next.flv = r_reg.flags_save;
				r_next.system_mode[VIPU_SYM_GIE] = 1'b1;
				r_next.st = VIPU_IDLE;
			end
			default: begin
				r_next.st = VIPU_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r_reg <= '0;
			r_reg.st <= VIPU_IDLE;
			r_reg.system_mode <= VIPU_RST_SYSTEM_MODE;
			r_reg.req_stat <= VIPU_RST_REQ_STATUS;
			r_reg.mask <= VIPU_RST_LEVEL_MASK;
			r_reg.prio <= VIPU_RST_LEVEL_PRIO;
			r_reg.fvp_h <= VIPU_RST_FVP;
			r_reg.fvp_l <= VIPU_RST_FVP;
		end else begin
			r_reg <= r_next;
		end
	end

	assign reg_rdata = r_reg.rdata;
	assign irq_pulse = r_reg.irq;
	assign int_acknowledge = r_reg.ack;
	assign stack_push = r_reg.push;
	assign stack_data = r_reg.push_data;
	assign stack_pop = r_reg.pop;
	assign vec_rd = r_reg.vrd;
	assign vec_addr = r_reg.vaddr;
	assign pc_load = r_reg.pcl;
	assign pc_value = r_reg.pcv;
	assign flags_load = r_reg.fll;
	assign flags_value = r_reg.flv;
	assign fast_status = r_reg.fstat;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_ack_clears_gie;
		@(posedge clock) disable iff (rst)
		r_reg.ack |-> $past(r_reg.system_mode[VIPU_SYM_GIE]) && !r_reg.system_mode[VIPU_SYM_GIE];
	endproperty
	a_ack_clears_gie: assert property (p_ack_clears_gie) else $error("ack without enable or enable not cleared");

	property p_no_ack_disabled;
		@(posedge clock) disable iff (rst)
		!r_reg.system_mode[VIPU_SYM_GIE] && !global_int_on && !reg_wr |=> !r_reg.ack;
	endproperty
	a_no_ack_disabled: assert property (p_no_ack_disabled) else $error("serviced while globally disabled");

	// Entry length is carried by the sequencer's own counter instead of a long repetition
	property p_normal_len;
		@(posedge clock) disable iff (rst)
		r_reg.ack && !r_reg.is_fast |-> ##21 (r_reg.pcl && r_reg.cnt == 5'(VIPU_NORMAL_ENTRY_CYC));
	endproperty
	a_normal_len: assert property (p_normal_len) else $error("normal entry not 22 cycles");

	property p_branch_at_count;
		@(posedge clock) disable iff (rst)
		r_reg.pcl && $past(r_reg.st) == VIPU_BRANCH |-> r_reg.cnt == 5'(VIPU_NORMAL_ENTRY_CYC);
	endproperty
	a_branch_at_count: assert property (p_branch_at_count) else $error("branch before entry count");

	property p_fast_len;
		@(posedge clock) disable iff (rst)
		r_reg.ack && r_reg.is_fast |-> ##5 (r_reg.pcl && r_reg.fstat && !r_reg.push);
	endproperty
	a_fast_len: assert property (p_fast_len) else $error("fast entry not 6 cycles");

	property p_push_order;
		@(posedge clock) disable iff (rst)
		r_reg.ack && !r_reg.is_fast |-> r_reg.push && r_reg.push_data == r_reg.pc_save[7:0]
			##1 r_reg.push && r_reg.push_data == r_reg.pc_save[15:8]
			##1 r_reg.push && r_reg.push_data == r_reg.flags_save ##1 !r_reg.push ##1 r_reg.vrd;
	endproperty
	a_push_order: assert property (p_push_order) else $error("entry push order wrong");

	property p_vec_legal;
		@(posedge clock) disable iff (rst)
		r_reg.vrd && !$past(r_reg.vrd) |-> !r_reg.vaddr[0] && (r_reg.vaddr[7:2] != 6'h0f);
	endproperty
	a_vec_legal: assert property (p_vec_legal) else $error("vector address odd or reserved");

	property p_return_restores;
		@(posedge clock) disable iff (rst)
		r_reg.st == VIPU_IDLE && return_from_int && !r_reg.fstat |=> r_reg.pop ##2 r_reg.pop
			##1 (r_reg.pcl && r_reg.fll && r_reg.system_mode[VIPU_SYM_GIE]);
	endproperty
	a_return_restores: assert property (p_return_restores) else $error("return did not restore");

	property p_fast_return;
		@(posedge clock) disable iff (rst)
		r_reg.st == VIPU_IDLE && return_from_int && r_reg.fstat |=>
			r_reg.pcl && !r_reg.fstat && r_reg.flv == $past(r_reg.shadow) && {r_reg.fvp_h, r_reg.fvp_l} == $past(pc_in);
	endproperty
	a_fast_return: assert property (p_fast_return) else $error("fast return swap wrong");

	property p_hw_pulse;
		@(posedge clock) disable iff (rst)
		|hw_evt |=> r_reg.irq && (r_reg.hw_pend & $past(hw_evt)) == $past(hw_evt);
	endproperty
	a_hw_pulse: assert property (p_hw_pulse) else $error("hardware pending not set or pulsed");

endmodule : vipu_core

/* logic/vipu_pkg.sv */
// Constants, types and register map of the vectored interrupt priority unit
package vipu_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int VIPU_LVLS = 8;
	localparam int VIPU_SRCS = 4;
	localparam int VIPU_NSRC = VIPU_LVLS * VIPU_SRCS;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] VIPU_OFS_FVP_HIGH = 8'hda;
	localparam logic [7:0] VIPU_OFS_FVP_LOW = 8'hdb;
	localparam logic [7:0] VIPU_OFS_REQ_STATUS = 8'hdc;
	localparam logic [7:0] VIPU_OFS_LEVEL_MASK = 8'hdd;
	localparam logic [7:0] VIPU_OFS_SYSTEM_MODE = 8'hde;
	localparam logic [7:0] VIPU_OFS_LEVEL_PRIO = 8'hff;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int VIPU_SYM_GIE = 0;
	localparam int VIPU_SYM_FAST_EN = 1;
	localparam int VIPU_SYM_FSEL_LSB = 2;
	localparam logic [7:0] VIPU_SYM_USED = 8'h9f;
	localparam logic [7:0] VIPU_RST_SYSTEM_MODE = 8'h00;
	localparam logic [7:0] VIPU_RST_REQ_STATUS = 8'h00;
	localparam logic [7:0] VIPU_RST_LEVEL_MASK = 8'h00;
	localparam logic [7:0] VIPU_RST_LEVEL_PRIO = 8'h00;
	localparam logic [7:0] VIPU_RST_FVP = 8'h00;
	// Levels whose pending flags are cleared by hardware on acknowledge
	localparam logic [7:0] VIPU_HW_CLR_LEVELS = 8'h0f;

	// ----------------------------------------
	// Entry timing
	// ----------------------------------------
	localparam int VIPU_NORMAL_ENTRY_CYC = 22;
	localparam int VIPU_FAST_ENTRY_CYC = 6;

	// ----------------------------------------
	// Group order lookup, index {prio7,prio4,prio1}; 0=A 1=B 2=C, first group in bits 5:4
	// ----------------------------------------
	localparam logic [47:0] VIPU_GRP_ORDER = {
		6'b00_10_01, // 111 unused, A > C > B
		6'b00_10_01, // 110 A > C > B
		6'b10_01_00, // 101 C > B > A
		6'b10_00_01, // 100 C > A > B
		6'b01_00_10, // 011 B > A > C
		6'b00_01_10, // 010 A > B > C
		6'b01_10_00, // 001 B > C > A
		6'b00_01_10  // 000 unused, A > B > C
	};

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		VIPU_IDLE = 4'h0,
		VIPU_PUSH_H = 4'h1,
		VIPU_PUSH_F = 4'h3,
		VIPU_FETCH_H = 4'h2,
		VIPU_FETCH_L = 4'h6,
		VIPU_CAPT = 4'h7,
		VIPU_BRANCH = 4'h5,
		VIPU_FAST = 4'hc,
		VIPU_POP_F = 4'hd,
		VIPU_POP_H = 4'hf,
		VIPU_POP_L = 4'he
	} vipu_state_e;

endpackage : vipu_pkg

/* logic/vipu_prio_resolve.sv */
// Level priority resolver: group and subgroup ordering from the priority register
module vipu_prio_resolve
	import vipu_pkg::*;
(
	input wire logic [7:0] req,
	input wire logic [7:0] prio,
	output logic found,
	output logic [2:0] level
);

	logic [2:0] seq [8];
	logic [5:0] order;
	logic [2:0] a0, a1, b0, b1, b2, b3a, b3b, c0, c1, c2;
	int k;

	always_comb begin
		order = VIPU_GRP_ORDER[{prio[7], prio[4], prio[1]} * 6 +: 6];
		// Group A ordering
		a0 = prio[0] ? 3'h1 : 3'h0;
		a1 = prio[0] ? 3'h0 : 3'h1;
		// Group B: subgroup of levels 3 and 4, then level 2 against it
		b3a = prio[3] ? 3'h4 : 3'h3;
		b3b = prio[3] ? 3'h3 : 3'h4;
		b0 = prio[2] ? b3a : 3'h2;
		b1 = prio[2] ? b3b : b3a;
		b2 = prio[2] ? 3'h2 : b3b;
		// Group C ordering
		c0 = prio[5] ? 3'h7 : 3'h5;
		c1 = 3'h6;
		c2 = prio[5] ? 3'h5 : 3'h7;
		for (int i = 0; i < 8; i++) begin
			seq[i] = 3'h0;
		end
		k = 0;
		for (int g = 2; g >= 0; g--) begin
			case (order[g*2 +: 2])
				2'h0: begin
					seq[k] = a0;
					seq[k+1] = a1;
					k = k + 2;
				end
				2'h1: begin
					seq[k] = b0;
					seq[k+1] = b1;
					seq[k+2] = b2;
					k = k + 3;
				end
				default: begin
					seq[k] = c0;
					seq[k+1] = c1;
					seq[k+2] = c2;
					k = k + 3;
				end
			endcase
		end
		// Scan from lowest priority so the highest requester is written last
		found = 1'b0;
		level = 3'h0;
		for (int j = 7; j >= 0; j--) begin
			if (req[seq[j]]) begin
				found = 1'b1;
				level = seq[j];
			end
		end
	end

endmodule : vipu_prio_resolve

/* tb/vipu_core_model.sv */
// Core-side model: program counter, flags, stack and vector ROM
module vipu_core_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic stack_push,
	input wire logic [7:0] stack_data,
	input wire logic stack_pop,
	input wire logic [7:0] vec_addr,
	input wire logic pc_load,
	input wire logic [15:0] pc_value,
	input wire logic flags_load,
	input wire logic [7:0] flags_value,
	output logic instr_end,
	output logic [15:0] pc_in,
	output logic [7:0] flags_in,
	output logic [7:0] pop_data,
	output logic [7:0] vec_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] stk[$];
	logic [1:0] phase;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			stk.delete();
			phase <= 2'h0;
			instr_end <= 1'b0;
			pc_in <= 16'h1234;
			flags_in <= 8'h3c;
			pop_data <= 8'h00;
			vec_data <= 8'h00;
		end else begin
			phase <= phase + 2'h1;
			instr_end <= (phase == 2'h3);
			// ROM answers from the registered address, held while the address holds
			vec_data <= vec_addr ^ 8'ha5;
			if (stack_push) begin
				stk.push_back(stack_data);
			end
			if (stack_pop && stk.size() > 0) begin
				void'(stk.pop_back());
			end
			// Top byte stands while a pop is requested; an empty stack bus shows the inverse
			pop_data <= (stk.size() > 0) ? stk[$] : ~pop_data;
			if (pc_load) begin
				pc_in <= pc_value;
			end
			if (flags_load) begin
				flags_in <= flags_value;
			end else if (pc_load) begin
				// Service routine leaves altered flags behind
				flags_in <= ~flags_in;
			end
		end
	end
endmodule : vipu_core_model

/* tb/vipu_core_tb_top.sv */
// Self-checking testbench of the vectored interrupt priority unit
module vipu_core_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import vipu_pkg::*;
	logic clock, rst, reg_wr, instr_end, return_from_int, global_int_on, global_int_off;
	logic irq_pulse, int_acknowledge, stack_push, stack_pop, vec_rd, pc_load, flags_load, fast_status;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, flags_in, pop_data, vec_data, stack_data, vec_addr;
	logic [7:0] flags_value, d, fl_val, pushed[$];
	logic [15:0] pc_in, pc_value, ld_val;
	logic [VIPU_NSRC-1:0] src_event, src_flag, src_enable;
	int err_count, checks, n_ack, n_ld, n_irq, t, t_ack, t_ld;
	// Address, write data, expected read back
	logic [23:0] rows [9] = '{24'hdd_a5_a5, 24'hde_ff_9f, 24'hde_00_00, 24'hff_3c_3c, 24'hda_12_12,
		24'hdb_34_34, 24'hdc_ff_00, 24'h10_ff_00, 24'hdd_ff_ff};

	vipu_core u_vipu_core (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .src_event(src_event), .src_flag(src_flag),
		.src_enable(src_enable), .instr_end(instr_end), .return_from_int(return_from_int),
		.global_int_on(global_int_on), .global_int_off(global_int_off), .pc_in(pc_in),
		.flags_in(flags_in), .pop_data(pop_data), .vec_data(vec_data), .irq_pulse(irq_pulse),
		.int_acknowledge(int_acknowledge), .stack_push(stack_push), .stack_data(stack_data),
		.stack_pop(stack_pop), .vec_rd(vec_rd), .vec_addr(vec_addr), .pc_load(pc_load),
		.pc_value(pc_value), .flags_load(flags_load), .flags_value(flags_value), .fast_status(fast_status));
	vipu_core_model u_vipu_core_model (.clock(clock), .rst(rst), .stack_push(stack_push),
		.stack_data(stack_data), .stack_pop(stack_pop), .vec_addr(vec_addr), .pc_load(pc_load),
		.pc_value(pc_value), .flags_load(flags_load), .flags_value(flags_value), .instr_end(instr_end),
		.pc_in(pc_in), .flags_in(flags_in), .pop_data(pop_data), .vec_data(vec_data));

	// ----
	// Clock and output monitor
	// ----
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Sampled mid-cycle so flop outputs have settled
	always @(negedge clock) begin
		if (int_acknowledge) begin
			t_ack = t;
			n_ack++;
			pushed.delete();
		end
		if (pc_load) begin
			t_ld = t;
			n_ld++;
			ld_val = pc_value;
		end
		if (flags_load) fl_val = flags_value;
		if (stack_push) pushed.push_back(stack_data);
		if (irq_pulse) n_irq++;
		t++;
	end

	// ----
	// Tasks
	// ----
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task results;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wr <= 1'b1;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		@(posedge clock);
		@(negedge clock);
		d = reg_rdata;
	endtask : rd
	task go(input int w);
		@(posedge clock);
		case (w)
			0: global_int_on <= 1'b1;
			1: global_int_off <= 1'b1;
			default: return_from_int <= 1'b1;
		endcase
		@(posedge clock);
		{global_int_on, global_int_off, return_from_int} <= 3'h0;
	endtask : go
	task ev(input int i);
		@(posedge clock);
		src_event[i] <= 1'b1;
		@(posedge clock);
		src_event <= '0;
	endtask : ev
	task wait_ld;
		int n0;
		n0 = n_ld;
		for (int k = 0; k < 200 && n_ld == n0; k++) @(negedge clock);
		if (n_ld == n0) begin
			err_count++;
			$display("BAD %0t no load of the program counter", $time);
			results;
		end
	endtask : wait_ld
	// No acknowledge may appear over 40 cycles
	task quiet;
		int n0;
		n0 = n_ack;
		repeat (40) @(negedge clock);
		chk(16'(n_ack), 16'(n0));
	endtask : quiet
	function automatic logic [15:0] vpc(input int l, input int s);
		logic [7:0] v;
		v = 8'hc0 + 8'(l * 8 + s * 2);
		return {v ^ 8'ha5, (v + 8'h01) ^ 8'ha5};
	endfunction : vpc
	// Normal entry, software clear of the served flag, return
	task serve(input int l, input int s);
		wait_ld;
		chk(16'(t_ld - t_ack), 16'(VIPU_NORMAL_ENTRY_CYC - 1));
		chk(ld_val, vpc(l, s));
		chk({pushed[0], pushed[1]}, 16'h3412);
		chk({pushed[2], 8'(pushed.size())}, 16'h3c03);
		rd(VIPU_OFS_SYSTEM_MODE);
		chk(16'(d[0]), 16'h0000);
		@(posedge clock);
		src_flag[l * 4 + s] <= 1'b0;
		go(2);
		wait_ld;
		chk(ld_val, 16'h1234);
		chk(16'(fl_val), 16'h003c);
		$display("served level %0d source %0d", l, s);
	endtask : serve

	// ----
	// Main sequence
	// ----
	initial begin
		rst = 1'b1;
		{reg_wr, return_from_int, global_int_on, global_int_off} = 4'h0;
		{reg_addr, reg_wdata} = 16'h0000;
		{src_event, src_flag} = '0;
		src_enable = ~(32'h1 << 12);
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		rd(VIPU_OFS_REQ_STATUS);
		chk(16'(d), 16'h0000);
		rd(VIPU_OFS_SYSTEM_MODE);
		chk(16'(d), 16'h0000);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16]);
			chk(16'(d), 16'(rows[i][7:0]));
		end
		$display("register test done");
		// Requests while disabled are recorded only; level 3 source is switched off
		ev(4);
		ev(12);
		rd(VIPU_OFS_REQ_STATUS);
		chk(16'(d), 16'h0002);
		chk(16'(n_irq), 16'h0001);
		quiet;
		go(0);
		serve(1, 0);
		rd(VIPU_OFS_REQ_STATUS);
		chk(16'(d), 16'h0000);
		rd(VIPU_OFS_SYSTEM_MODE);
		chk(16'(d), 16'h0001);
		quiet;
		wr(VIPU_OFS_LEVEL_MASK, 8'hbf);
		@(posedge clock);
		src_flag[24] <= 1'b1;
		quiet;
		rd(VIPU_OFS_REQ_STATUS);
		chk(16'(d), 16'h0040);
		wr(VIPU_OFS_LEVEL_MASK, 8'hff);
		serve(6, 0);
		$display("service test done");
		// Group order B over C over A, then C over B over A
		go(1);
		wr(VIPU_OFS_LEVEL_PRIO, 8'h02);
		ev(0);
		ev(8);
		@(posedge clock);
		src_flag[20] <= 1'b1;
		go(0);
		serve(2, 0);
		serve(5, 0);
		serve(0, 0);
		go(1);
		wr(VIPU_OFS_LEVEL_PRIO, 8'h82);
		ev(8);
		@(posedge clock);
		src_flag[21] <= 1'b1;
		src_flag[23] <= 1'b1;
		go(0);
		serve(5, 1);
		serve(5, 3);
		serve(2, 0);
		$display("priority test done");
		// Fast path on level 1; pointer loaded before enabling
		wr(VIPU_OFS_FVP_HIGH, 8'h56);
		wr(VIPU_OFS_FVP_LOW, 8'h78);
		wr(VIPU_OFS_SYSTEM_MODE, 8'h07);
		ev(4);
		wait_ld;
		chk(16'(t_ld - t_ack), 16'(VIPU_FAST_ENTRY_CYC - 1));
		chk(ld_val, 16'h5678);
		chk({7'h00, fast_status, 8'(pushed.size())}, 16'h0100);
		rd(VIPU_OFS_FVP_HIGH);
		chk(16'(d), 16'h0012);
		go(2);
		wait_ld;
		chk(ld_val, 16'h1234);
		chk({fl_val, 7'h00, fast_status}, 16'h3c00);
		rd(VIPU_OFS_FVP_LOW);
		chk(16'(d), 16'h0078);
		go(1);
		ev(4);
		quiet;
		$display("fast test done");
		// Reset in mid-run drops the recorded level 1 request
		rd(VIPU_OFS_REQ_STATUS);
		chk(16'(d), 16'h0002);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(VIPU_OFS_REQ_STATUS);
		chk(16'(d), 16'h0000);
		rd(VIPU_OFS_SYSTEM_MODE);
		chk({d, 7'h00, fast_status}, 16'h0000);
		$display("mid-run reset test done");
		results;
	end
endmodule : vipu_core_tb_top
